// ===== rtl/wake_axil_regs.sv
// wake_axil_regs: axi4-lite slave holding the filter set and wake control
// assumes: one outstanding write and one read, word aligned accesses
`timescale 1ns/1ns
`default_nettype none
module wake_axil_regs
  import wake_filter_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          frame_seen_set,
  output logic [1023:0]      mask_flat,
  output logic [63:0]        cmd_flat,
  output logic [63:0]        ofs_flat,
  output logic [127:0]       crc_flat,
  output logic [31:0]        wake_ctrl
);
  logic [31:0] regs_reg [0:40];
  logic [31:0] regs_next [0:40];
  logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0]  widx, ridx;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign widx = aw_addr_reg[7:2];
  assign ridx = s_axi_araddr[7:2];

  always_comb begin
    for (int i = 0; i < 41; i++) begin
      regs_next[i] = regs_reg[i];
    end
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !s_axi_rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (aw_have_reg && w_have_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_SLVERR;
      if (widx <= ADDR_WAKE_CTRL[7:2]) begin
        bresp_next = RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            regs_next[widx][8*b +: 8] = w_data_reg[8*b +: 8];
          end
        end
      end
    end
    // hardware set wins over a software write
    if (frame_seen_set) begin
      regs_next[ADDR_WAKE_CTRL[7:2]][WCS_FRAME_SEEN_BIT] = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = (ridx <= ADDR_WAKE_CTRL[7:2]) ? RESP_OKAY : RESP_SLVERR;
      rdata_next  = (ridx <= ADDR_WAKE_CTRL[7:2]) ? regs_reg[ridx] : 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 41; i++) begin
        regs_reg[i] <= WAKE_CTRL_RESET;
      end
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 41; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_mask
      assign mask_flat[32*g +: 32] = regs_reg[g];
    end
  endgenerate
  assign cmd_flat  = {regs_reg[33], regs_reg[32]};
  assign ofs_flat  = {regs_reg[35], regs_reg[34]};
  assign crc_flat  = {regs_reg[39], regs_reg[38], regs_reg[37], regs_reg[36]};
  assign wake_ctrl = regs_reg[40];
endmodule : wake_axil_regs
`default_nettype wire

// ===== rtl/wake_crc16_unit.sv
// wake_crc16_unit: one filter's byte select and crc-16 accumulation
// assumes: byte_valid pulses once per frame byte, frame_start clears state
`timescale 1ns/1ns
`default_nettype none
module wake_crc16_unit
  import wake_filter_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         frame_start,
  input  wire logic         byte_valid,
  input  wire logic [7:0]   byte_data,
  input  wire logic [10:0]  byte_index,
  input  wire logic [7:0]   start_offset,
  input  wire logic [127:0] byte_mask,
  output logic      [15:0]  crc_value
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [11:0] rel;
  logic        take;

  always_comb begin
    rel  = {1'b0, byte_index} - {4'h0, start_offset};
    take = 1'b0;
    if (byte_index >= {3'h0, start_offset} && rel < 12'(MASK_BITS)) begin
      take = byte_mask[rel[6:0]];
    end
  end

  always_comb begin
    crc_next = crc_reg;
    if (frame_start) begin
      crc_next = CRC16_INIT;
    end else if (byte_valid && take) begin
      for (int b = 0; b < 8; b++) begin
        if (crc_next[15] ^ byte_data[b]) begin
          crc_next = {crc_next[14:0], 1'b0} ^ CRC16_POLY;
        end else begin
          crc_next = {crc_next[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_reg <= CRC16_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc_value = crc_reg;
endmodule : wake_crc16_unit
`default_nettype wire

// ===== rtl/wake_filter_pkg.sv
// wake_filter_pkg: constants shared by the wakeup frame filter bank
// assumes: 32-bit AXI4-Lite register access, 8 filters
package wake_filter_pkg;
  localparam int NUM_FILTERS      = 8;
  localparam int MASK_BITS        = 128;
  localparam int MASK_WORDS       = 4;
  localparam int CMD_ENABLE_BIT   = 0;
  localparam int CMD_ATYPE_LO     = 2;
  localparam int CMD_ATYPE_HI     = 3;
  localparam logic [1:0] ATYPE_UNICAST   = 2'h0;
  localparam logic [1:0] ATYPE_MULTICAST = 2'h2;
  localparam int WCS_FRAME_EN_BIT   = 2;
  localparam int WCS_GLOBAL_UC_BIT  = 9;
  localparam int WCS_FRAME_SEEN_BIT = 6;
  // byte addresses
  localparam logic [7:0] ADDR_MASK_BASE   = 8'h00;
  localparam logic [7:0] ADDR_CMD_LO      = 8'h80;
  localparam logic [7:0] ADDR_CMD_HI      = 8'h84;
  localparam logic [7:0] ADDR_OFS_LO      = 8'h88;
  localparam logic [7:0] ADDR_OFS_HI      = 8'h8c;
  localparam logic [7:0] ADDR_CRC_BASE    = 8'h90;
  localparam logic [7:0] ADDR_WAKE_CTRL   = 8'ha0;
  localparam logic [31:0] WAKE_CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] CRC16_INIT      = 16'hffff;
  localparam logic [15:0] CRC16_POLY      = 16'h8005;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : wake_filter_pkg

// ===== rtl/wakeup_frame_filter.sv
// wakeup_frame_filter: wake frame crc filter bank in the receive path
// assumes: rx bytes arrive from the mac receive path with start/end
// marks and frame classification valid at rx_end
//
// Functional notes
// - masked bytes feed the filter crc
// - mask built from four words, lsb first
// - address type 00 unicast, 10 multicast, x1 any
// - command bit 0 enables the filter
// - eight-bit offset counts from destination address
// - match only when crc equals expected value
// - wake only with enable and qualifying case
// - broadcast match always wakes when enabled
// - global unicast enable wakes unicast matches
// - receive-filter-passed frames qualify by address type
`timescale 1ns/1ns
`default_nettype none
module wakeup_frame_filter
  import wake_filter_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_start,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  input  wire logic        rx_broadcast,
  input  wire logic        rx_multicast,
  input  wire logic        rx_unicast,
  input  wire logic        rx_filter_pass,
  output logic             wake_pulse,
  output logic [7:0]       filter_hit
);
  logic [1023:0] mask_flat;
  logic [63:0]   cmd_flat;
  logic [63:0]   ofs_flat;
  logic [127:0]  crc_flat;
  logic [31:0]   wake_ctrl;
  logic [10:0]   index_reg, index_next;
  logic          check_reg, check_next;
  logic          bc_reg, mc_reg, uc_reg, pass_reg;
  logic          bc_next, mc_next, uc_next, pass_next;
  logic          wake_reg, wake_next;
  logic [7:0]    hit_reg, hit_next;
  logic [7:0]    qualify;
  logic [15:0]   crc_val [0:NUM_FILTERS-1];

  wake_axil_regs u_regs (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .frame_seen_set (wake_reg),
    .mask_flat      (mask_flat),
    .cmd_flat       (cmd_flat),
    .ofs_flat       (ofs_flat),
    .crc_flat       (crc_flat),
    .wake_ctrl      (wake_ctrl)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame byte position and end-of-frame classification capture
  always_comb begin
    index_next = index_reg;
    check_next = 1'b0;
    bc_next    = bc_reg;
    mc_next    = mc_reg;
    uc_next    = uc_reg;
    pass_next  = pass_reg;
    if (rx_start) begin
      index_next = 11'h000;
    end else if (rx_valid && index_reg != 11'h7ff) begin
      index_next = index_reg + 11'h001;
    end
    if (rx_end) begin
      check_next = 1'b1;
      bc_next    = rx_broadcast;
      mc_next    = rx_multicast;
      uc_next    = rx_unicast;
      pass_next  = rx_filter_pass;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_reg <= 11'h000;
      check_reg <= 1'b0;
      bc_reg    <= 1'b0;
      mc_reg    <= 1'b0;
      uc_reg    <= 1'b0;
      pass_reg  <= 1'b0;
    end else begin
      index_reg <= index_next;
      check_reg <= check_next;
      bc_reg    <= bc_next;
      mc_reg    <= mc_next;
      uc_reg    <= uc_next;
      pass_reg  <= pass_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-filter crc engines and qualification
  genvar f;
  generate
    for (f = 0; f < NUM_FILTERS; f++) begin : g_filt
      logic [3:0]  cmd;
      logic [1:0]  atype;
      logic        crc_ok;
      wake_crc16_unit u_crc (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .frame_start  (rx_start),
        .byte_valid   (rx_valid && !rx_start),
        .byte_data    (rx_data),
        .byte_index   (index_reg),
        .start_offset (ofs_flat[8*f +: 8]),
        .byte_mask    (mask_flat[128*f +: 128]),
        .crc_value    (crc_val[f])
      );
      assign cmd    = cmd_flat[8*f +: 4];
      assign atype  = cmd[CMD_ATYPE_HI:CMD_ATYPE_LO];
      assign crc_ok = crc_val[f] == crc_flat[16*f +: 16];
      assign qualify[f] = cmd[CMD_ENABLE_BIT] && crc_ok && (
        (bc_reg && !mc_reg && !uc_reg) ||
        (wake_ctrl[WCS_GLOBAL_UC_BIT] && uc_reg && !bc_reg && !mc_reg) ||
        (pass_reg && atype == ATYPE_MULTICAST && mc_reg && !bc_reg && !uc_reg) ||
        (pass_reg && atype == ATYPE_UNICAST && uc_reg && !bc_reg && !mc_reg) ||
        (pass_reg && atype[0]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // wake event
  always_comb begin
    wake_next = 1'b0;
    hit_next  = hit_reg;
    if (check_reg && wake_ctrl[WCS_FRAME_EN_BIT]) begin
      wake_next = |qualify;
      if (|qualify) begin
        hit_next = qualify;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reg <= 1'b0;
      hit_reg  <= 8'h00;
    end else begin
      wake_reg <= wake_next;
      hit_reg  <= hit_next;
    end
  end

  assign wake_pulse = wake_reg;
  assign filter_hit = hit_reg;
endmodule : wakeup_frame_filter
`default_nettype wire

// ===== test/rx_frame_source.sv
// rx_frame_source: receive path model feeding frames to the filter bank
// assumes: send_frame is called right after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module rx_frame_source (
  input  wire logic       aclk,
  output logic            rx_start,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            rx_broadcast,
  output logic            rx_multicast,
  output logic            rx_unicast,
  output logic            rx_filter_pass
);
  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    rx_data = 8'ha5;
    {rx_broadcast, rx_multicast, rx_unicast, rx_filter_pass} = 4'h5;
  end
  ////////////////////////////////////////
  task automatic send_frame(input int len, input logic [3:0] cls, input int gap);
    rx_start <= 1'b1;
    @(posedge aclk);
    rx_start <= 1'b0;
    for (int k = 0; k < len; k++) begin
      rx_valid <= 1'b1;
      rx_data <= 8'(k * 7 + 3);
      @(posedge aclk);
      if (gap > 0) begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        repeat (gap) @(posedge aclk);
      end
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    {rx_broadcast, rx_multicast, rx_unicast, rx_filter_pass} <= cls;
    @(posedge aclk);
    rx_end <= 1'b0;
    // idle lines show the inverse so a stale value never passes as good
    rx_data <= ~rx_data;
    {rx_broadcast, rx_multicast, rx_unicast, rx_filter_pass} <= ~cls;
  endtask : send_frame
endmodule : rx_frame_source
`default_nettype wire

// ===== test/tb_top.sv
// tb_top: self-checking bench for the wake filter bank
// assumes: rx_frame_source model, monitor bound at the foot
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import wake_filter_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake_pulse;
  logic        rx_start, rx_valid, rx_end, rx_broadcast, rx_multicast, rx_unicast, rx_filter_pass;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, filter_hit;
  logic [31:0] s_axi_wdata, s_axi_rdata, dat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] good_crc;
  int          err_total, cmp_count, cycles;

  wakeup_frame_filter u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_start, .rx_valid, .rx_data, .rx_end, .rx_broadcast, .rx_multicast, .rx_unicast,
    .rx_filter_pass, .wake_pulse, .filter_hit
  );
  rx_frame_source u_src (
    .aclk, .rx_start, .rx_valid, .rx_data, .rx_end, .rx_broadcast, .rx_multicast, .rx_unicast,
    .rx_filter_pass
  );
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      wrap_up();
    end
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input int k);
    logic [7:0] d;
    d = 8'(k * 7 + 3);
    for (int i = 0; i < 8; i++) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC16_POLY : {c[14:0], 1'b0};
    return c;
  endfunction : crc_step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
  endtask : rd
  // cls is {broadcast, multicast, unicast, filter pass}
  task automatic frame(input logic [3:0] cls, input int gap, input logic [7:0] exp_hit);
    int pulses;
    logic [7:0] hit;
    pulses = 0;
    hit = 8'h00;
    u_src.send_frame(40, cls, gap);
    repeat (6) begin
      @(negedge aclk);
      if (wake_pulse === 1'b1) begin
        pulses++;
        hit = filter_hit;
      end
    end
    @(posedge aclk);
    chk(32'(pulses), {31'h0, exp_hit != 8'h00});
    chk({24'h0, hit}, {24'h0, exp_hit});
  endtask : frame
  // filter 1 stays enabled with a wrong crc throughout
  task automatic setf(input logic [31:0] wc, input logic [7:0] cmd0);
    wr(ADDR_WAKE_CTRL, wc, rsp);
    wr(ADDR_CMD_LO, {16'h0, 8'h05, cmd0}, rsp);
  endtask : setf
  ////////////////////////////////////////
  task automatic t_regs;
    rd(ADDR_WAKE_CTRL, dat, rsp);
    chk(dat, WAKE_CTRL_RESET);
    rd(8'h04, dat, rsp);
    chk(dat, 32'h0);
    good_crc = crc_step(crc_step(crc_step(crc_step(CRC16_INIT, 2), 3), 5), 35);
    for (int f = 0; f < 8; f += 7) begin
      wr(8'(f * 16), 32'h0000_000b, rsp);
      wr(8'(f * 16 + 4), 32'h0000_0002, rsp);
    end
    wr(8'h10, 32'h0000_000b, rsp);
    wr(8'h14, 32'h0000_0002, rsp);
    wr(ADDR_OFS_LO, 32'h0000_0202, rsp);
    wr(ADDR_OFS_HI, 32'h0200_0000, rsp);
    wr(ADDR_CRC_BASE, {good_crc ^ 16'h0001, good_crc}, rsp);
    wr(8'h9c, {good_crc, 16'h0}, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(8'h74, dat, rsp);
    chk(dat, 32'h0000_0002);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(8'ha4, dat, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk(dat, 32'h0);
    wr(8'ha8, 32'hffff_ffff, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask : t_regs
  task automatic t_any_type;
    setf(32'h004, 8'h05);
    frame(4'h3, 0, 8'h01);
    frame(4'h4, 0, 8'h00);
    frame(4'h3, 2, 8'h01);
  endtask : t_any_type
  task automatic t_enable;
    setf(32'h000, 8'h05);
    frame(4'h8, 0, 8'h00);
    setf(32'h004, 8'h00);
    frame(4'h8, 0, 8'h00);
    setf(32'h004, 8'h01);
    frame(4'h8, 0, 8'h01);
    wr(ADDR_CMD_HI, 32'h0100_0000, rsp);
    frame(4'h9, 0, 8'h81);
    wr(ADDR_CMD_HI, 32'h0, rsp);
  endtask : t_enable
  task automatic t_unicast;
    setf(32'h004, 8'h09);
    frame(4'h2, 0, 8'h00);
    setf(32'h204, 8'h09);
    frame(4'h2, 0, 8'h01);
  endtask : t_unicast
  task automatic t_types;
    setf(32'h004, 8'h09);
    frame(4'h5, 0, 8'h01);
    frame(4'h3, 0, 8'h00);
    setf(32'h004, 8'h01);
    frame(4'h5, 0, 8'h00);
    frame(4'h3, 1, 8'h01);
    // the last wake leaves the sticky seen bit beside the enable
    rd(ADDR_WAKE_CTRL, dat, rsp);
    chk(dat, (32'h1 << WCS_FRAME_EN_BIT) | (32'h1 << WCS_FRAME_SEEN_BIT));
  endtask : t_types
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_any_type();
    t_enable();
    t_unicast();
    t_types();
    wrap_up();
  end
endmodule : tb_top

bind wakeup_frame_filter wake_filter_monitor u_mon (
  .aclk, .aresetn, .s_axi_awready, .s_axi_awvalid, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .rx_end, .wake_pulse, .filter_hit
);
`default_nettype wire

// ===== test/wake_filter_monitor.sv
// wake_filter_monitor: port-level checks on the wake filter bank
// assumes: bound onto wakeup_frame_filter, one clock domain
`timescale 1ns/1ns
`default_nettype none
module wake_filter_monitor
  import wake_filter_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        rx_end,
  input wire logic        wake_pulse,
  input wire logic [7:0]  filter_hit
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_wake_one_cycle: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse wider than one cycle");
  a_wake_after_end: assert property (wake_pulse |-> $past(rx_end, 1) || $past(rx_end, 2))
    else $error("wake pulse without a frame end");
  a_wake_has_hit: assert property (wake_pulse |-> filter_hit != 8'h00)
    else $error("wake pulse with no filter hit");
  a_hit_steady: assert property (!wake_pulse |-> $stable(filter_hit))
    else $error("filter hit changed without a wake");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'ha0
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : wake_filter_monitor
`default_nettype wire
